// >>> src/uart_trig_pkg.sv
package uart_trig_pkg;
   // clock and bit timing
   localparam int unsigned CLK_HZ = 100_000_000; // mclk rate in hertz
   localparam int ACC_W = 27;
   localparam int RATE_W = 23;
   // the phase accumulator wraps once per half bit period
   localparam logic [ACC_W:0] HALF_LIMIT = (ACC_W + 1)'(CLK_HZ / 2);
   localparam logic [2:0] HALVES_PER_BIT = 3'h2;
   localparam logic [RATE_W-1:0] RATE_MIN = 23'h00012c; // 300 bit/s
   localparam logic [RATE_W-1:0] RATE_MAX = 23'h4c4b40; // 5000000 bit/s
   localparam logic [3:0] BAUD_USER = 4'h9; // selects user_bit_rate
   localparam logic [RATE_W-1:0] PRESET_RATE [9] = '{
      23'h000258, 23'h0004b0, 23'h000960, 23'h0012c0, 23'h002580,
      23'h004b00, 23'h009600, 23'h00e100, 23'h01c200};
   // character format
   localparam int CHAR_W = 8;
   localparam logic [3:0] MIN_LEN = 4'h5;
   localparam logic [8:0] DONT_CARE = 9'h100;
   // line sources
   localparam int NUM_ANA = 4;
   localparam int NUM_DIG = 16;
   localparam int SMP_W = 8;
   localparam logic [4:0] DIG_BASE = 5'h04;
   // register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMP = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BAUD = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_USER = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_RXSRC = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_TXSRC = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CHAR = 8'h1c;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [1:0] {COND_START, COND_STOP, COND_DATA, COND_ERROR} cond_e;
   typedef enum logic [1:0] {QUAL_EQ, QUAL_GT, QUAL_LT, QUAL_RSV} qual_e;
   typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_RSV} parity_e;
   typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2, STOP_RSV} stop_e;

   typedef logic [NUM_ANA-1:0][SMP_W-1:0] ana_t;

   // control register layout, low bit first from the bottom
   typedef struct packed {
      logic [17:0] pad;
      logic enable;
      logic shiftMsb;       // shift_order_setting
      stop_e stopLen;       // stop_length_setting
      logic idleHigh;       // idle_level_setting
      parity_e parity;      // parity_setting
      logic [1:0] lenCode;  // character_length minus five
      qual_e qual;          // data_compare_qualifier
      cond_e cond;          // trigger_condition_select
      logic lineTx;         // watched_line_select
   } cfg_s;

   // receive_line_input and transmit_line_input layout
   typedef struct packed {
      logic [15:0] pad;
      logic [SMP_W-1:0] threshold;
      logic [2:0] pad2;
      logic [4:0] sel;
   } src_s;

   typedef struct packed {
      logic parityErr;
      logic stopErr;
      logic [CHAR_W-1:0] data;
   } char_s;
endpackage

// >>> src/uart_serial_trigger.sv
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module char_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8,
   parameter int LVL_W = $clog2(DEPTH + 1)
) (
   input wire logic mclk, // system clock
   input wire logic arst_n, // async reset, low active
   input wire logic inVld, // writer offers a word
   output logic inRdy, // room for a word
   input wire logic [WIDTH-1:0] inData, // word offered
   output logic outVld, // a word is held
   input wire logic outRdy, // reader takes the word
   output logic [WIDTH-1:0] outData, // oldest word
   output logic [LVL_W-1:0] level // words held
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [LVL_W-1:0] cnt;
   } fifo_s;

   fifo_s s;
   fifo_s n;
   logic push;
   logic pop;

   // flags straight from the count so full and empty never lie
   assign inRdy = s.cnt != LVL_W'(DEPTH);
   assign outVld = s.cnt != '0;
   assign outData = s.mem[s.rp];
   assign level = s.cnt;
   assign push = inVld && inRdy;
   assign pop = outRdy && outVld;

   // pointers wrap at the depth, which need not be a power of two
   always_comb begin
      n = s;
      if (push) begin
         n.mem[s.wp] = inData;
         n.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
      end
      n.cnt = s.cnt + LVL_W'(push) - LVL_W'(pop);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule

module uart_serial_trigger #(
   parameter int DEPTH = uart_trig_pkg::FIFO_DEPTH
) (
   input wire logic mclk, // 100 MHz clock
   input wire logic arst_n, // async reset, low active
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [uart_trig_pkg::ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire uart_trig_pkg::ana_t anaSample, // sampled analog channels
   input wire logic [uart_trig_pkg::NUM_DIG-1:0] digIn, // digital input pins
   output logic trigger // one-cycle trigger pulse
);
   import uart_trig_pkg::*;

   localparam int LVL_W = $clog2(DEPTH + 1);

   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP, ST_PUSH} rx_e;

   typedef struct packed {
      cfg_s cfg;
      logic [8:0] cmp;
      logic [3:0] baudSel;
      logic [RATE_W-1:0] userRate;
      src_s rxSrc;
      src_s txSrc;
      logic [NUM_DIG-1:0] digMeta;
      logic [NUM_DIG-1:0] digSync;
      logic lineNorm;
      rx_e st;
      logic [ACC_W-1:0] acc;
      logic [2:0] halfCnt;
      logic [3:0] bitCnt;
      logic [CHAR_W-1:0] shreg;
      logic perr;
      logic serr;
      char_s charOut;
      logic trig;
      logic [15:0] trigCount;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_s;

   state_s s;
   state_s n;
   logic [RATE_W-1:0] curRate;
   logic [ACC_W:0] accSum;
   logic tick;
   logic centre;
   logic stopLeave;
   logic rxLine;
   logic txLine;
   logic [3:0] len;
   logic [CHAR_W-1:0] dataAligned;
   logic match;
   logic popReq;
   logic fifoInRdy;
   logic fifoOutVld;
   char_s fifoOut;
   logic [LVL_W-1:0] fifoLevel;

   // slice one source to a logic level; analog uses its own threshold
   function automatic logic slice_line(src_s src, ana_t ana, logic [NUM_DIG-1:0] dig);
      if (src.sel < DIG_BASE) begin
         return ana[src.sel[1:0]] >= src.threshold;
      end
      return dig[4'(src.sel - DIG_BASE)];
   endfunction

   // rate lookup; out of range user rates are clamped, not rejected
   function automatic logic [RATE_W-1:0] bit_rate(logic [3:0] sel, logic [RATE_W-1:0] user);
      if (sel == BAUD_USER) begin
         if (user < RATE_MIN) begin
            return RATE_MIN;
         end
         return (user > RATE_MAX) ? RATE_MAX : user;
      end
      return (sel < BAUD_USER) ? PRESET_RATE[sel] : PRESET_RATE[0];
   endfunction

   assign rxLine = slice_line(s.rxSrc, anaSample, s.digSync);
   assign txLine = slice_line(s.txSrc, anaSample, s.digSync);
   assign curRate = bit_rate(s.baudSel, s.userRate);
   assign len = MIN_LEN + 4'(s.cfg.lenCode);
   assign accSum = {1'b0, s.acc} + (ACC_W + 1)'(curRate);
   assign tick = (s.st != ST_IDLE) && (s.st != ST_PUSH) && (accSum >= HALF_LIMIT);
   assign centre = tick && (s.halfCnt == HALVES_PER_BIT - 3'h1);
   // stop span in half bits, left half a bit early to catch the next start
   assign stopLeave = (s.st == ST_STOP) && tick &&
                      (s.halfCnt == HALVES_PER_BIT + 3'(s.cfg.stopLen) - 3'h1);

   // lsb-first data collects at the top and is shifted down
   assign dataAligned = s.cfg.shiftMsb ? s.shreg : s.shreg >> (4'(CHAR_W) - len);

   always_comb begin
      unique case (s.cfg.qual)
         QUAL_GT: match = {1'b0, dataAligned} > s.cmp;
         QUAL_LT: match = {1'b0, dataAligned} < s.cmp;
         default: match = {1'b0, dataAligned} == s.cmp;
      endcase
      if (s.cmp == DONT_CARE) begin
         match = 1'b1;
      end
   end

   // receiver, trigger and register next state
   always_comb begin
      n = s;
      n.trig = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      popReq = 1'b0;
      // pins pass two flops before use
      n.digMeta = digIn;
      n.digSync = s.digMeta;
      // watched line, normalised so idle reads one
      n.lineNorm = (s.cfg.lineTx ? txLine : rxLine) ~^ s.cfg.idleHigh;
      if (tick) begin
         n.acc = ACC_W'(accSum - HALF_LIMIT);
         n.halfCnt = s.halfCnt + 3'h1;
      end else if (s.st != ST_IDLE) begin
         n.acc = ACC_W'(accSum);
      end
      unique case (s.st)
         ST_IDLE: begin
            // departure from idle restarts bit timer
            if (s.cfg.enable && !s.lineNorm) begin
               n.st = ST_START;
               n.acc = '0;
               n.halfCnt = '0;
            end
         end
         ST_START: begin
            // start verified at half a bit; a glitch returns to idle
            if (tick) begin
               n.halfCnt = '0;
               n.bitCnt = '0;
               n.shreg = '0;
               n.perr = 1'b0;
               n.serr = 1'b0;
               n.st = s.lineNorm ? ST_IDLE : ST_DATA;
               n.trig = !s.lineNorm && (s.cfg.cond == COND_START);
            end
         end
         ST_DATA: begin
            if (centre) begin
               n.halfCnt = '0;
               n.bitCnt = s.bitCnt + 4'h1;
               n.shreg = s.cfg.shiftMsb ? {s.shreg[CHAR_W-2:0], s.lineNorm}
                                        : {s.lineNorm, s.shreg[CHAR_W-1:1]};
               if (s.bitCnt == len - 4'h1) begin
                  n.st = (s.cfg.parity == PAR_NONE) ? ST_STOP : ST_PARITY;
               end
            end
         end
         ST_PARITY: begin
            if (centre) begin
               n.halfCnt = '0;
               n.st = ST_STOP;
               // odd wants an odd count of ones with the parity bit
               n.perr = (^s.shreg ^ s.lineNorm) ^ (s.cfg.parity == PAR_ODD);
               n.trig = n.perr && (s.cfg.cond == COND_ERROR);
            end
         end
         ST_STOP: begin
            // every half-bit sample inside the stop must be idle
            if (tick && !s.lineNorm) begin
               n.serr = 1'b1;
            end
            if (stopLeave) begin
               n.st = ST_PUSH;
               n.charOut = '{parityErr: s.perr, stopErr: n.serr, data: dataAligned};
               unique case (s.cfg.cond)
                  COND_STOP: n.trig = 1'b1;
                  COND_DATA: n.trig = match;
                  COND_ERROR: n.trig = n.serr;
                  COND_START: n.trig = 1'b0;
               endcase
            end
         end
         ST_PUSH: begin
            // a full fifo holds the receiver here, so characters are missed
            if (fifoInRdy) begin
               n.st = ST_IDLE;
            end
         end
         default: n.st = ST_IDLE;
      endcase
      if (n.trig) begin
         n.trigCount = s.trigCount + 16'h1;
      end
      // apb setup: answer next cycle, read data and pop taken here
      if (psel && !penable) begin
         n.pready = 1'b1;
         n.prdata = '0;
         unique case (paddr)
            OFS_CTRL: n.prdata = s.cfg;
            OFS_CMP: n.prdata = 32'(s.cmp);
            OFS_BAUD: n.prdata = 32'(s.baudSel);
            OFS_USER: n.prdata = 32'(s.userRate);
            OFS_RXSRC: n.prdata = s.rxSrc;
            OFS_TXSRC: n.prdata = s.txSrc;
            OFS_STATUS: n.prdata = {8'(fifoLevel), 7'h0, s.st != ST_IDLE, s.trigCount};
            OFS_CHAR: begin
               n.prdata = {fifoOutVld, 21'h0, fifoOut};
               popReq = !pwrite;
            end
            default: n.pslverr = 1'b1;
         endcase
      end
      // apb write commits at the completing access edge only
      if (psel && penable && s.pready && pwrite) begin
         unique case (paddr)
            OFS_CTRL: n.cfg = cfg_s'({18'h0, pwdata[13:0]});
            OFS_CMP: n.cmp = pwdata[8:0];
            OFS_BAUD: n.baudSel = pwdata[3:0];
            OFS_USER: n.userRate = pwdata[RATE_W-1:0];
            OFS_RXSRC: n.rxSrc = src_s'({16'h0, pwdata[15:8], 3'h0, pwdata[4:0]});
            OFS_TXSRC: n.txSrc = src_s'({16'h0, pwdata[15:8], 3'h0, pwdata[4:0]});
            default: begin end // read-only words ignore writes; the trigger count keeps counting
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.cmp <= DONT_CARE;
         s.cfg.idleHigh <= 1'b1;
      end else begin
         s <= n;
      end
   end

   char_fifo #(.WIDTH($bits(char_s)), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_fifo (
      .mclk(mclk),
      .arst_n(arst_n),
      .inVld(s.st == ST_PUSH),
      .inRdy(fifoInRdy),
      .inData(s.charOut),
      .outVld(fifoOutVld),
      .outRdy(popReq),
      .outData(fifoOut),
      .level(fifoLevel)
   );

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign trigger = s.trig;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   trig_one_cycle_a: assert property (trigger |=> !trigger)
      else $error("trigger held longer than one cycle");
   start_trig_a: assert property ((trigger && s.cfg.cond == COND_START)
      |-> ($past(s.st) == ST_START && s.st == ST_DATA))
      else $error("start trigger without verified start bit");
   start_idle_a: assert property (($past(s.st) == ST_IDLE && s.st == ST_START)
      |-> (!$past(s.lineNorm) && s.acc == '0))
      else $error("start hunt left idle without a departure");
   equal_match_a: assert property ((trigger && s.cfg.cond == COND_DATA &&
      s.cfg.qual == QUAL_EQ && s.cmp != DONT_CARE) |-> s.charOut.data == s.cmp[7:0])
      else $error("equal trigger on differing character");
   greater_match_a: assert property ((trigger && s.cfg.cond == COND_DATA &&
      s.cfg.qual == QUAL_GT && s.cmp != DONT_CARE) |-> {1'b0, s.charOut.data} > s.cmp)
      else $error("greater trigger on smaller character");
   dont_care_a: assert property ((stopLeave && s.cfg.cond == COND_DATA &&
      s.cmp == DONT_CARE) |=> trigger)
      else $error("don't-care compare did not trigger");
   bit_count_a: assert property ((s.st == ST_DATA) |-> s.bitCnt < len)
      else $error("data bit count beyond character length");
   error_cause_a: assert property ((trigger && s.cfg.cond == COND_ERROR)
      |-> (s.perr || s.charOut.stopErr))
      else $error("error trigger without parity or stop fault");
   centre_spacing_a: assert property ((s.st == ST_DATA && centre)
      |=> !centre ##1 (s.halfCnt <= HALVES_PER_BIT))
      else $error("bit centres closer than one bit period");
   push_hold_a: assert property ((s.st == ST_PUSH && !fifoInRdy) |=> s.st == ST_PUSH)
      else $error("character dropped while fifo full");
endmodule

// >>> bench/serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
   input wire logic mclk, // bench clock
   output logic line // observed serial line
);
   int bitClks = 20; // clocks per bit
   bit idleHigh = 1'b1; // line level between frames
   initial line = 1'b1;
   // logical one is idle; an idle-low line carries every bit inverted
   task automatic put(input logic v, input int n);
      line <= idleHigh ? v : ~v;
      repeat (n) @(posedge mclk);
   endtask
   // par 0 none 1 odd 2 even; stopH in half bits; bad flags corrupt on purpose
   task automatic send(input logic [7:0] d, input int len, par, stopH,
         input bit msb, badP, badS);
      logic p;
      p = ^(d & 8'((1 << len) - 1)) ^ (par == 1);
      put(1'b0, bitClks);
      for (int i = 0; i < len; i++) put(msb ? d[len - 1 - i] : d[i], bitClks);
      if (par != 0) put(p ^ badP, bitClks);
      // stop then idle gap; a bad stop is short so it cannot pass for a start
      if (badS) put(1'b0, bitClks * 3 / 5);
      put(1'b1, bitClks * (stopH + 4) / 2);
   endtask
endmodule

// >>> bench/uart_serial_trigger_tb.sv
`timescale 1ns/1ps
module uart_serial_trigger_tb;
   import uart_trig_pkg::*;
   logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, trigger, line;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   ana_t anaSample;
   logic [NUM_DIG-1:0] digIn;
   int errorCnt = 0;
   int testsRun = 0;
   int pulses = 0;
   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // pin 3 and analog input 2 carry the line, the rest its inverse, so a wrong pick shows
   always_comb begin
      digIn = {NUM_DIG{~line}};
      digIn[3] = line;
      for (int k = 0; k < NUM_ANA; k++) anaSample[k] = (line ^ (k != 2)) ? 8'hc0 : 8'h20;
   end
   // a stretched trigger pulse shows up as extra counts here
   always @(posedge mclk) begin
      if (trigger === 1'b1) pulses++;
   end
   uart_serial_trigger uart_serial_trigger_inst (.mclk(mclk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .anaSample(anaSample),
      .digIn(digIn), .trigger(trigger));
   serial_tx_model serial_tx_model_inst (.mclk(mclk), .line(line));

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one transfer; an idle cycle follows so the next setup never lands in the same step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) chk(32'h0, 32'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   function automatic logic [31:0] ctl(int cnd, q, n, p, ih, st, m, tx);
      return 32'(tx | cnd << 1 | q << 3 | (n - 5) << 5 | p << 7 | ih << 9 | st << 10 | m << 12);
   endfunction
   // receiver parked while the line settles to its new idle level
   task automatic setup(input logic [31:0] c);
      wr(OFS_CTRL, c);
      serial_tx_model_inst.idleHigh = c[9];
      serial_tx_model_inst.put(1'b1, 40);
      wr(OFS_CTRL, c | 32'h2000);
   endtask
   task automatic xfer(input logic [7:0] d, input int len, par, stopH, input bit msb, bp, bs,
         input int expTrig, input logic [31:0] expChar);
      logic [31:0] s0, s1, ch;
      int p0;
      rd(OFS_STATUS, s0);
      p0 = pulses;
      serial_tx_model_inst.send(d, len, par, stopH, msb, bp, bs);
      rd(OFS_STATUS, s1);
      chk({16'h0, s1[15:0] - s0[15:0]}, 32'(expTrig));
      chk(32'(pulses - p0), 32'(expTrig));
      rd(OFS_CHAR, ch);
      chk(ch & 32'h8000_03ff, expChar);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      logic e;
      rd(OFS_CTRL, q);
      chk(q, 32'h0000_0200);
      rd(OFS_CMP, q);
      chk(q, 32'h0000_0100);
      apb(1'b0, 8'h20, 32'h0, q, e);
      chk({e, q[30:0]}, 32'h8000_0000);
      apb(1'b1, 8'h24, 32'hffff_ffff, q, e);
      chk({31'h0, e}, 32'h1);
      wr(OFS_CTRL, 32'hffff_c000);
      rd(OFS_CTRL, q);
      chk(q, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_start;
      wr(OFS_RXSRC, 32'h0000_ff07);
      wr(OFS_TXSRC, 32'h0000_8002);
      wr(OFS_BAUD, 32'h8);
      serial_tx_model_inst.bitClks = 868;
      setup(ctl(0, 0, 8, 0, 1, 0, 0, 0));
      xfer(8'h5a, 8, 0, 2, 0, 0, 0, 1, 32'h8000_005a);
      wr(OFS_BAUD, 32'h9);
      wr(OFS_USER, 32'd6000000);
      serial_tx_model_inst.bitClks = 20;
      setup(ctl(1, 0, 8, 0, 1, 0, 0, 0));
      xfer(8'ha5, 8, 0, 2, 0, 0, 0, 1, 32'h8000_00a5);
      $display("t_start done");
   endtask
   task automatic t_qual;
      logic [8:0] cv [8] = '{9'h050, 9'h051, 9'h04f, 9'h050, 9'h051, 9'h050, 9'h100, 9'h100};
      int qu [8] = '{0, 0, 1, 1, 2, 2, 0, 1};
      int ex [8] = '{1, 0, 1, 0, 1, 0, 1, 1};
      for (int i = 0; i < 8; i++) begin
         wr(OFS_CMP, 32'(cv[i]));
         setup(ctl(2, qu[i], 8, 0, 1, 0, 0, 0));
         xfer(8'h50, 8, 0, 2, 0, 0, 0, ex[i], 32'h8000_0050);
      end
      $display("t_qual done");
   endtask
   // transmit line on analog input, idle low, every length, parity and stop code
   task automatic t_format;
      wr(OFS_RXSRC, 32'h0000_ff04);
      for (int n = 5; n < 9; n++) begin
         setup(ctl(1, 0, n, n % 3, 0, n % 3, n % 2, 1));
         xfer(8'hb3, n, n % 3, n % 3 + 2, n % 2, 0, 0, 1,
            32'h8000_0000 | 32'(8'hb3 & 8'((1 << n) - 1)));
      end
      $display("t_format done");
   endtask
   task automatic t_error;
      wr(OFS_RXSRC, 32'h7);
      setup(ctl(3, 0, 8, 2, 1, 0, 0, 0));
      xfer(8'h3c, 8, 2, 2, 0, 1, 0, 1, 32'h8000_023c);
      xfer(8'h3c, 8, 2, 2, 0, 0, 1, 1, 32'h8000_013c);
      xfer(8'h3c, 8, 2, 2, 0, 1, 1, 2, 32'h8000_033c);
      xfer(8'h3c, 8, 2, 2, 0, 0, 0, 0, 32'h8000_003c);
      $display("t_error done");
   endtask
   // nine characters into eight places: the ninth waits in the receiver, then drain to empty
   task automatic t_fifo;
      logic [31:0] q;
      setup(ctl(0, 0, 8, 0, 1, 0, 0, 0));
      for (int i = 0; i < 9; i++) serial_tx_model_inst.send(8'(i + 1), 8, 0, 2, 0, 0, 0);
      rd(OFS_STATUS, q);
      chk({24'h0, q[31:24]}, 32'd8);
      for (int i = 0; i < 10; i++) begin
         rd(OFS_CHAR, q);
         chk(i < 9 ? q & 32'h8000_00ff : {31'h0, q[31]},
            i < 9 ? 32'h8000_0000 | 32'(i + 1) : 32'h0);
      end
      $display("t_fifo done");
   endtask
   // reset, then the scenarios in turn
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      t_regs;
      t_start;
      t_qual;
      t_format;
      t_error;
      t_fifo;
      end_sim;
   end
   // watchdog, well beyond the expected run of about 18000 cycles
   initial begin
      repeat (60000) @(posedge mclk);
      errorCnt++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim;
   end
endmodule
